// ==== design/tpc_pair_ctrl.sv ====
`timescale 1ns/1ps
`include "tpc_defines.svh"

// Behaviour
// - disabled channel skips detection, pins repurposed
// - polarity selects amplifier side, single only
// - mode bit selects single or differential
// - only seven pin combinations; decode pin functions
// - drift compensation bit per channel
// - aux output mode: sense, static, led
// - interrupt enable gates touch interrupts
// - centre field maps to four baseline values
// - differential centre value forced to zero
// - single threshold is code times 512 minus 32768
// - single exceedance run raises irq and flag
// - differential window from -512n to 512n-1
// - outside window run raises irq and flag
// - count field k needs k+1 exceedances
module tpc_pair_ctrl (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset, active high
    input wire logic regWrite, // register write strobe
    input wire logic regRead, // register read strobe
    input wire logic [7:0] regAddr, // register offset
    input wire logic [7:0] regWrData, // register write data
    output logic [7:0] regRdData, // register read data
    input wire logic measValid, // one measurement done
    input wire logic measChannel, // 0 = channel 12, 1 = channel 13
    input wire tpc_pkg::tpc_sample_t measData, // measured value
    input wire logic [1:0] flagClear, // clear status flags
    output logic [1:0] touchFlag, // sticky detection flags
    output logic touchIrq, // touch interrupt level
    output tpc_pkg::tpc_pin_t pin12Func, // pin 12 function
    output tpc_pkg::tpc_pin_t pin13Func, // pin 13 function
    output logic comboIllegal, // forbidden pin combination
    output logic pairDifferential, // pair in differential mode
    output logic [1:0] ampNegative, // channel on negative amp side
    output logic [1:0] driftComp, // dynamic calibration on
    output tpc_pkg::tpc_aux_t auxMode12, // channel 12 aux mode
    output tpc_pkg::tpc_aux_t auxMode13, // channel 13 aux mode
    output logic [1:0] auxDrive, // drive programmed output value
    output tpc_pkg::tpc_sample_t centerValue, // calibration centre
    output tpc_pkg::tpc_sample_t thrSingle, // single threshold
    output tpc_pkg::tpc_sample_t thrDiffLow, // window low bound
    output tpc_pkg::tpc_sample_t thrDiffHigh // window high bound
);
    import tpc_pkg::*;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // single threshold from 7-bit code
    function automatic tpc_sample_t singleThr(input logic [6:0] code);
        logic signed [17:0] v;
        v = 18'(`TPC_SGL_THR_BASE) + 18'(code) * 18'(`TPC_THR_STEP);
        return v[15:0];
    endfunction

    // aux field of a channel from cfg2
    function automatic tpc_aux_t auxOf(input logic [7:0] c, input logic ch);
        logic [1:0] f;
        f = ch ? c[`TPC_B_AUX13 +: 2] : c[`TPC_B_AUX12 +: 2];
        return tpc_aux_t'(f);
    endfunction

    // ------------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------------
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [1:0] centerSel;
    logic [6:0] sglThrCode;
    logic [5:0] difThrCode;
    logic [3:0] cntCode;
    logic [7:0] next_cfg1;
    logic [7:0] next_cfg2;
    logic [1:0] next_centerSel;
    logic [6:0] next_sglThrCode;
    logic [5:0] next_difThrCode;
    logic [3:0] next_cntCode;
    logic [7:0] next_regRdData;

    // writes and registered reads
    always_comb begin
        next_cfg1 = cfg1;
        next_cfg2 = cfg2;
        next_centerSel = centerSel;
        next_sglThrCode = sglThrCode;
        next_difThrCode = difThrCode;
        next_cntCode = cntCode;
        next_regRdData = regRdData;
        if (regWrite) begin
            case (regAddr)
                `TPC_OFS_CFG1: next_cfg1 = regWrData;
                `TPC_OFS_CFG2: next_cfg2 = regWrData;
                `TPC_OFS_CENTER: next_centerSel = regWrData[1:0];
                `TPC_OFS_SGL_THR: next_sglThrCode = regWrData[6:0];
                `TPC_OFS_DIF_THR: next_difThrCode = regWrData[5:0];
                `TPC_OFS_CNT: next_cntCode = regWrData[3:0];
                default: ;
            endcase
        end
        if (regRead) begin
            case (regAddr)
                `TPC_OFS_CFG1: next_regRdData = cfg1;
                `TPC_OFS_CFG2: next_regRdData = cfg2 & `TPC_CFG2_RD_MASK;
                `TPC_OFS_CENTER: next_regRdData = {6'h00, centerSel};
                `TPC_OFS_SGL_THR: next_regRdData = {1'b0, sglThrCode};
                `TPC_OFS_DIF_THR: next_regRdData = {2'h0, difThrCode};
                `TPC_OFS_CNT: next_regRdData = {4'h0, cntCode};
                default: next_regRdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg1 <= `TPC_RST_CFG1;
            cfg2 <= `TPC_RST_CFG2;
            centerSel <= `TPC_RST_CENTER;
            sglThrCode <= `TPC_RST_SGL_THR;
            difThrCode <= `TPC_RST_DIF_THR;
            cntCode <= `TPC_RST_CNT;
            regRdData <= 8'h00;
        end else begin
            cfg1 <= next_cfg1;
            cfg2 <= next_cfg2;
            centerSel <= next_centerSel;
            sglThrCode <= next_sglThrCode;
            difThrCode <= next_difThrCode;
            cntCode <= next_cntCode;
            regRdData <= next_regRdData;
        end
    end

    // ------------------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------------------
    logic isDiff;
    logic invDrv;
    logic [1:0] senseEn;
    logic [1:0] irqEn;
    logic [1:0] detectOn;
    tpc_sample_t thrS;
    tpc_sample_t thrLo;
    tpc_sample_t thrHi;
    tpc_pin_t p12;
    tpc_pin_t p13;
    logic badCombo;
    tpc_sample_t center;
    logic [1:0] ampNeg;

    // field extraction and detection gating
    always_comb begin
        isDiff = cfg1[`TPC_B_DIFF];
        invDrv = cfg1[`TPC_B_INVDRV];
        senseEn = {cfg1[`TPC_B_EN13], cfg1[`TPC_B_EN12]};
        irqEn = {cfg2[`TPC_B_IRQEN13], cfg2[`TPC_B_IRQEN12]};
        // static aux mode suppresses sensing
        detectOn[0] = senseEn[0] && auxOf(cfg2, 1'b0) != AUX_STATIC;
        detectOn[1] = senseEn[1] && auxOf(cfg2, 1'b1) != AUX_STATIC;
        thrS = singleThr(sglThrCode);
        thrHi = tpc_sample_t'(16'(difThrCode) * 16'(`TPC_THR_STEP) - 16'd1);
        thrLo = tpc_sample_t'(16'd0 - 16'(difThrCode) * 16'(`TPC_THR_STEP));
    end

    // polarity and centre value
    always_comb begin
        // differential wires 12 positive and 13 negative
        ampNeg = isDiff ? 2'b10 : {cfg1[`TPC_B_POL13], cfg1[`TPC_B_POL12]};
        if (isDiff) begin
            center = 16'sh0000;
        end else begin
            center = tpc_sample_t'(16'(`TPC_CENTER_BASE)
                + 16'(centerSel) * 16'(`TPC_CENTER_STEP));
        end
    end

    // pin function combinations
    always_comb begin
        p12 = PIN_OFF;
        p13 = PIN_OFF;
        badCombo = 1'b0;
        unique case ({invDrv, senseEn[1], senseEn[0], isDiff})
            4'b1000: begin
                p13 = PIN_INVDRV;
                p12 = PIN_REFCAP;
            end
            4'b0000: p13 = PIN_IRQOUT;
            4'b0010: begin
                p13 = PIN_IRQOUT;
                p12 = PIN_SENSE;
            end
            4'b0100: p13 = PIN_SENSE;
            4'b0110, 4'b0111: begin
                p13 = PIN_SENSE;
                p12 = PIN_SENSE;
            end
            4'b0001: ;
            default: badCombo = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------------
    // exceedance counters and flags
    // ------------------------------------------------------------------------
    logic [4:0] runCnt [2];
    logic [4:0] next_runCnt [2];
    logic [1:0] next_touchFlag;
    logic [1:0] ledHold;
    logic [1:0] next_ledHold;
    logic [1:0] hit;
    logic ch;
    logic over;

    always_comb begin
        next_runCnt = runCnt;
        next_ledHold = ledHold;
        hit = 2'b00;
        // differential pair counts on channel 12 slot
        ch = isDiff ? 1'b0 : measChannel;
        if (isDiff) begin
            over = measData < thrLo || measData > thrHi;
        end else begin
            over = measData > thrS;
        end
        if (measValid && detectOn[ch]) begin
            if (over) begin
                if (runCnt[ch] == {1'b0, cntCode}) begin
                    hit[ch] = 1'b1;
                end
                if (runCnt[ch] <= {1'b0, cntCode}) begin
                    next_runCnt[ch] = runCnt[ch] + 5'd1;
                end
            end else begin
                next_runCnt[ch] = 5'd0;
            end
            // led mode drives for one interval after an over-threshold measurement
            next_ledHold[ch] = over;
        end
        // set wins over clear
        next_touchFlag = (touchFlag & ~flagClear) | (hit & irqEn);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            runCnt[0] <= 5'd0;
            runCnt[1] <= 5'd0;
            touchFlag <= 2'b00;
            ledHold <= 2'b00;
        end else begin
            runCnt <= next_runCnt;
            touchFlag <= next_touchFlag;
            ledHold <= next_ledHold;
        end
    end

    // ------------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------------
    logic [1:0] next_auxDrive;

    always_comb begin
        next_auxDrive[0] = auxOf(cfg2, 1'b0) == AUX_STATIC
            || (auxOf(cfg2, 1'b0) == AUX_LED && ledHold[0]);
        next_auxDrive[1] = auxOf(cfg2, 1'b1) == AUX_STATIC
            || (auxOf(cfg2, 1'b1) == AUX_LED && ledHold[1]);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            touchIrq <= 1'b0;
            pin12Func <= PIN_OFF;
            pin13Func <= PIN_OFF;
            comboIllegal <= 1'b0;
            pairDifferential <= 1'b0;
            ampNegative <= 2'b00;
            driftComp <= 2'b00;
            auxMode12 <= AUX_SENSE;
            auxMode13 <= AUX_SENSE;
            auxDrive <= 2'b00;
            centerValue <= 16'sh0000;
            thrSingle <= 16'sh0000;
            thrDiffLow <= 16'sh0000;
            thrDiffHigh <= 16'sh0000;
        end else begin
            touchIrq <= |next_touchFlag;
            pin12Func <= p12;
            pin13Func <= p13;
            comboIllegal <= badCombo;
            pairDifferential <= isDiff;
            ampNegative <= ampNeg;
            driftComp <= {cfg2[`TPC_B_DRIFT13], cfg2[`TPC_B_DRIFT12]};
            auxMode12 <= auxOf(cfg2, 1'b0);
            auxMode13 <= auxOf(cfg2, 1'b1);
            auxDrive <= next_auxDrive;
            centerValue <= center;
            thrSingle <= thrS;
            thrDiffLow <= thrLo;
            thrDiffHigh <= thrHi;
        end
    end
endmodule

// ==== design/tpc_defines.svh ====
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define TPC_OFS_CFG1 8'h32
`define TPC_OFS_CFG2 8'h33
`define TPC_OFS_CENTER 8'h34
`define TPC_OFS_SGL_THR 8'h35
`define TPC_OFS_DIF_THR 8'h36
`define TPC_OFS_CNT 8'h37

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TPC_RST_CFG1 8'h00
`define TPC_RST_CFG2 8'h00
`define TPC_RST_CENTER 2'h0
`define TPC_RST_SGL_THR 7'h00
`define TPC_RST_DIF_THR 6'h00
`define TPC_RST_CNT 4'h0

// ----------------------------------------------------------------------------
// field positions, first configuration register
// ----------------------------------------------------------------------------
`define TPC_B_DIFF 0
`define TPC_B_POL12 1
`define TPC_B_POL13 2
`define TPC_B_EN12 3
`define TPC_B_EN13 4
`define TPC_B_INVDRV 5

// ----------------------------------------------------------------------------
// field positions, second configuration register
// ----------------------------------------------------------------------------
`define TPC_B_IRQEN12 0
`define TPC_B_IRQEN13 1
`define TPC_B_AUX12 2
`define TPC_B_AUX13 4
`define TPC_B_DRIFT12 6
`define TPC_B_DRIFT13 7
`define TPC_CFG2_RD_MASK 8'h03

// ----------------------------------------------------------------------------
// threshold and centre arithmetic
// ----------------------------------------------------------------------------
`define TPC_THR_STEP 512
`define TPC_SGL_THR_BASE (-32768)
`define TPC_CENTER_STEP 8192
`define TPC_CENTER_BASE (-24576)

`endif

// ==== design/tpc_pkg.sv ====
package tpc_pkg;
    // function of one sensor pin
    typedef enum logic [2:0] {
        PIN_OFF = 3'b000,
        PIN_SENSE = 3'b001,
        PIN_REFCAP = 3'b010,
        PIN_INVDRV = 3'b011,
        PIN_IRQOUT = 3'b100
    } tpc_pin_t;

    // auxiliary output mode per channel
    typedef enum logic [1:0] {
        AUX_SENSE = 2'b00,
        AUX_STATIC = 2'b01,
        AUX_LED = 2'b10,
        AUX_RSVD = 2'b11
    } tpc_aux_t;

    typedef logic signed [15:0] tpc_sample_t;
endpackage

// ==== bench/tpc_pair_ctrl_assertions.sv ====
`timescale 1ns/1ps
module tpc_pair_ctrl_checker (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    input wire logic [7:0] regAddr, // register offset
    input wire logic [7:0] regWrData, // write data
    input wire logic [7:0] regRdData, // read data
    input wire logic measValid, // measurement done
    input wire logic [1:0] touchFlag, // detection flags
    input wire logic touchIrq, // touch interrupt
    input wire tpc_pkg::tpc_pin_t pin12Func, // pin 12 function
    input wire tpc_pkg::tpc_pin_t pin13Func, // pin 13 function
    input wire logic pairDifferential, // differential mode
    input wire logic [1:0] ampNegative, // negative amp side
    input wire tpc_pkg::tpc_aux_t auxMode12, // channel 12 aux mode
    input wire logic [1:0] auxDrive, // drive programmed value
    input wire tpc_pkg::tpc_sample_t centerValue, // centre
    input wire tpc_pkg::tpc_sample_t thrSingle, // single threshold
    input wire tpc_pkg::tpc_sample_t thrDiffLow // window low
);
    import tpc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_single_thr_map: assert property (
        regWrite && regAddr == 8'h35 |-> ##2 thrSingle == ({$past(regWrData[6:0], 2), 9'h000} ^ 16'h8000))
        else $error("single threshold decode wrong");
    a_diff_low_map: assert property (
        regWrite && regAddr == 8'h36 |-> ##2 thrDiffLow == -$signed({1'b0, $past(regWrData[5:0], 2), 9'h000}))
        else $error("window low bound decode wrong");
    a_center_diff_zero: assert property (
        pairDifferential && $past(pairDifferential) |-> centerValue == 16'h0000)
        else $error("centre not zero in differential");
    a_amp_diff_sides: assert property (
        pairDifferential && $past(pairDifferential) |-> ampNegative == 2'h2)
        else $error("amplifier sides wrong in differential");
    a_invdrv_refcap_pair: assert property (
        pin13Func == PIN_INVDRV |-> pin12Func == PIN_REFCAP)
        else $error("inverted drive without reference pin");
    a_irq_follows_flag: assert property (
        !$past(reset) |-> touchIrq == (|touchFlag))
        else $error("interrupt does not follow flags");
    a_flag_needs_meas: assert property (
        $rose(touchFlag[0]) |-> $past(measValid))
        else $error("flag rose without measurement");
    a_static_drive_on: assert property (
        auxMode12 == AUX_STATIC && $past(auxMode12) == AUX_STATIC |-> auxDrive[0])
        else $error("static mode not driving");
    a_cfg2_write_only: assert property (
        regRead && regAddr == 8'h33 |=> regRdData[7:2] == 6'h00)
        else $error("write-only bits read back");
endmodule

bind tpc_pair_ctrl tpc_pair_ctrl_checker chk_u (.clk_sys, .reset, .regWrite, .regRead, .regAddr,
    .regWrData, .regRdData, .measValid, .touchFlag, .touchIrq, .pin12Func, .pin13Func,
    .pairDifferential, .ampNegative, .auxMode12, .auxDrive, .centerValue, .thrSingle, .thrDiffLow);

// ==== bench/tpc_host_model.sv ====
`timescale 1ns/1ps
module tpc_host_model (
    input wire logic clk_sys, // system clock
    output logic regWrite, // write strobe
    output logic regRead, // read strobe
    output logic [7:0] regAddr, // register offset
    output logic [7:0] regWrData, // write data
    input wire logic [7:0] regRdData // read data
);
    logic diffMode = 1'b0; // last mode bit written
    // idle bus at time zero
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // one write; returns once decoded outputs have settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h32) diffMode = d[0];
        if (a == 8'h32 && d[0]) v[4] = v[3];
        if (a == 8'h33 && diffMode) begin
            v[1] = v[0];
            v[7] = v[6];
            if (v[5:4] == 2'h1) v[5:4] = 2'h0;
            if (v[3:2] == 2'h1) v[3:2] = 2'h0;
        end
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regWrData <= ~v;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // one read; data taken after the answer edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(posedge clk_sys);
        #1;
        d = regRdData;
    endtask
endmodule

// ==== bench/tpc_pair_ctrl_test.sv ====
`timescale 1ns/1ps
module tpc_pair_ctrl_test;
    import tpc_pkg::*;
    logic clk_sys, reset, regWrite, regRead, measValid, measChannel, touchIrq;
    logic comboIllegal, pairDifferential;
    tpc_aux_t auxMode12, auxMode13;
    logic [7:0] regAddr, regWrData, regRdData, rdv;
    logic [1:0] flagClear, touchFlag, ampNegative, auxDrive, driftComp;
    tpc_sample_t measData, centerValue, thrSingle, thrDiffLow, thrDiffHigh;
    tpc_pin_t pin12Func, pin13Func;
    int err_count = 0;
    int checked = 0;
    logic [13:0] tbl [7] = '{14'h81a, 14'h020, 14'h221, 14'h408, 14'h609, 14'h040, 14'h649};
    tpc_host_model host_u (.clk_sys, .regWrite, .regRead, .regAddr, .regWrData, .regRdData);
    tpc_pair_ctrl dut_u (.clk_sys, .reset, .regWrite, .regRead, .regAddr, .regWrData,
        .regRdData, .measValid, .measChannel, .measData, .flagClear, .touchFlag, .touchIrq,
        .pin12Func, .pin13Func, .comboIllegal, .pairDifferential, .ampNegative, .driftComp,
        .auxMode12, .auxMode13, .auxDrive, .centerValue, .thrSingle, .thrDiffLow,
        .thrDiffHigh);
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic meas(input logic ch, input tpc_sample_t v);
        @(posedge clk_sys);
        measValid <= 1'b1;
        measChannel <= ch;
        measData <= v;
        @(posedge clk_sys);
        measValid <= 1'b0;
        measData <= ~v;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic clr;
        @(posedge clk_sys);
        flagClear <= 2'h3;
        @(posedge clk_sys);
        flagClear <= 2'h0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic t_regs;
        for (int a = 8'h32; a < 8'h38; a++) begin
            host_u.rd(8'(a), rdv);
            chk(16'(rdv), 16'h0000);
        end
        host_u.wr(8'h33, 8'hc3);
        host_u.rd(8'h33, rdv);
        chk(16'(rdv), 16'h0003);
        chk(16'(driftComp), 16'h0003);
        host_u.wr(8'h38, 8'h5a);
        host_u.rd(8'h38, rdv);
        chk(16'(rdv), 16'h0000);
        host_u.wr(8'h33, 8'h04);
        chk(16'(auxDrive[0]), 16'h0001);
        chk(16'({auxMode13, auxMode12}), 16'h0001);
    endtask
    task automatic t_values;
        for (int c = 0; c < 4; c++) begin
            host_u.wr(8'h34, 8'(c));
            chk(centerValue, 16'(-24576 + 8192 * c));
            host_u.wr(8'h35, 8'(c * 63 / 2 + (c / 3) * 33));
            chk(thrSingle, 16'(-32768 + 512 * (c * 63 / 2 + (c / 3) * 33)));
            host_u.wr(8'h36, 8'(c * 21));
            chk(thrDiffLow, 16'(-512 * c * 21));
            chk(thrDiffHigh, 16'(512 * c * 21 - 1));
        end
        host_u.wr(8'h32, 8'h1e);
        chk(16'(ampNegative), 16'h0003);
        foreach (tbl[i]) begin
            host_u.wr(8'h32, tbl[i][13:6]);
            chk(16'({pin13Func, pin12Func}), 16'(tbl[i][5:0]));
            chk(16'({comboIllegal, pairDifferential}), 16'(tbl[i][6]));
        end
        // centre code 0 would give a nonzero value in single mode
        host_u.wr(8'h34, 8'h00);
        chk(centerValue, 16'h0000);
        chk(16'(ampNegative), 16'h0002);
    endtask
    task automatic t_runs;
        host_u.wr(8'h32, 8'h08);
        host_u.wr(8'h33, 8'h03);
        host_u.wr(8'h35, 8'h40);
        host_u.wr(8'h37, 8'h0f);
        repeat (15) meas(1'b0, 16'sd100);
        meas(1'b0, 16'sd0);
        repeat (15) meas(1'b0, 16'sd1);
        repeat (16) meas(1'b1, 16'sd100);
        chk(16'({touchIrq, touchFlag}), 16'h0000);
        meas(1'b0, 16'sd1);
        chk(16'({touchIrq, touchFlag}), 16'h0005);
        // led mode: drive after the over measurement, drop after an inside one
        host_u.wr(8'h33, 8'h0b);
        chk(16'(auxDrive), 16'h0001);
        meas(1'b0, 16'sd0);
        chk(16'(auxDrive), 16'h0000);
        clr();
        host_u.wr(8'h33, 8'h00);
        host_u.wr(8'h37, 8'h00);
        meas(1'b0, 16'sd0);
        meas(1'b0, 16'sd100);
        chk(16'(touchFlag), 16'h0000);
        host_u.wr(8'h32, 8'h19);
        host_u.wr(8'h33, 8'h03);
        host_u.wr(8'h36, 8'h01);
        meas(1'b0, 16'sd511);
        meas(1'b0, -16'sd512);
        chk(16'(touchFlag), 16'h0000);
        meas(1'b0, -16'sd513);
        chk(16'({touchIrq, touchFlag}), 16'h0005);
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        finish_test();
    end
    // reset, then scenarios
    initial begin
        reset = 1'b1;
        measValid = 1'b0;
        measChannel = 1'b0;
        measData = 16'h0000;
        flagClear = 2'h0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_values();
        t_runs();
        finish_test();
    end
endmodule
